/* File: hdl/eptmr_pkg.sv */
// Purpose: Constants and types shared by the eight-bit period timer
// Assumes: Core clock of 200 MHz, register port of eight-bit words
// Notes: Offsets index the plain register port directly
package eptmr_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] EPTMR_OFF_CONTROL = 3'h0;
  localparam logic [2:0] EPTMR_OFF_PERIOD = 3'h1;
  localparam logic [2:0] EPTMR_OFF_COUNT = 3'h2;
  localparam logic [2:0] EPTMR_OFF_STATUS = 3'h3;
  localparam logic [2:0] EPTMR_OFF_MASK = 3'h4;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int EPTMR_POST_LSB = 3;
  localparam int EPTMR_RUN_BIT = 2;
  localparam int EPTMR_PRE_LSB = 0;
  localparam logic [7:0] EPTMR_CONTROL_RST = 8'h00;
  localparam logic [7:0] EPTMR_CONTROL_MASK = 8'h7f;
  localparam logic [7:0] EPTMR_PERIOD_RST = 8'hff;
  localparam logic [7:0] EPTMR_COUNT_RST = 8'h00;
  // ----------------------------------------
  // Timing: instruction clock is one quarter of the core clock
  // ----------------------------------------
  localparam int EPTMR_INSTR_DIV = 4;
  localparam logic [1:0] EPTMR_INSTR_LAST = 2'(EPTMR_INSTR_DIV - 1);
  localparam logic [3:0] EPTMR_PRE_LAST_4 = 4'h3;
  localparam logic [3:0] EPTMR_PRE_LAST_16 = 4'hf;
  // Control register fields
  typedef struct packed {
    logic unused;
    logic [3:0] post_divide_select;
    logic timer_run;
    logic [1:0] pre_divide_select;
  } eptmr_control_t;
  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eptmr_req_t;
endpackage

/* File: hdl/eptmr_timer.sv */
// Purpose: Eight-bit period timer with prescaler, postscaler and match interrupt
// Assumes: Register strobes are one cycle, synchronous to core_clk
// Notes: Read data stands only in the cycle after the read strobe
//
// Overview of operation
// - Postscaler field n divides by n plus one
// - Run bit one runs, zero stops timer
// - Period register resets to all ones
// - Count register resets to zero
// - Control top bit reads as zero
// - Instruction clock prescaled by 1, 4, 16
// - Match wraps count, advances postscaler
// - Postscaler output sets match flag
// - Count or control write clears scalers
`timescale 1ns/1ps
module eptmr_timer
  import eptmr_pkg::*;
#(
  parameter int INSTR_DIV = EPTMR_INSTR_DIV // Core cycles per instruction tick
)
(
  input wire logic core_clk, // Core clock, 200 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [2:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, one cycle after strobe
  output logic irq, // Level interrupt
  output logic [7:0] count_out // Current count value
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The phase counter is two bits wide, so it serves dividers of one to four
  if (INSTR_DIV < 1 || INSTR_DIV > 4) begin : g_div_check
    $error("instruction divider must lie between one and four");
  end
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  eptmr_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Write strobe for one register offset
  function automatic logic wr_hit(input eptmr_req_t r, input logic [2:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction

  wire wr_control = wr_hit(req, EPTMR_OFF_CONTROL);
  wire wr_period = wr_hit(req, EPTMR_OFF_PERIOD);
  wire wr_count = wr_hit(req, EPTMR_OFF_COUNT);
  wire wr_status = wr_hit(req, EPTMR_OFF_STATUS);
  wire wr_mask = wr_hit(req, EPTMR_OFF_MASK);

  logic [7:0] control_q, period_q, count_q;
  logic [1:0] instr_q;
  logic [3:0] pre_q, post_q;
  logic flag_q, mask_q;
  eptmr_control_t ctl;
  assign ctl = eptmr_control_t'(control_q);

  // Scaler limit lookup
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    if (sel[1]) begin
      pre_last = EPTMR_PRE_LAST_16;
    end else if (sel[0]) begin
      pre_last = EPTMR_PRE_LAST_4;
    end else begin
      pre_last = 4'h0;
    end
  endfunction

  // ----------------------------------------
  // Timer datapath
  // ----------------------------------------
  // Tick chain: core clock, instruction tick, prescaler, count, postscaler.
  // The prescaler counts only while running, and the control write that stops
  // the timer clears its partial prescale, so a stopped timer holds zero.
  wire instr_tick = (instr_q == INSTR_LAST);
  wire pre_tick = instr_tick && ctl.timer_run &&
                  (pre_q == pre_last(ctl.pre_divide_select));
  wire match = (count_q == period_q);
  wire post_fire = pre_tick && match && (post_q == ctl.post_divide_select);
  wire scaler_clr = wr_count || wr_control;
  wire [3:0] pre_d = (scaler_clr || pre_tick) ? 4'h0 :
                     (instr_tick && ctl.timer_run) ? 4'(pre_q + 4'h1) : pre_q;
  // The postscaler advances once per period match and restarts when it fires
  wire [3:0] post_d = (scaler_clr || post_fire) ? 4'h0 :
                      (pre_tick && match) ? 4'(post_q + 4'h1) : post_q;
  // A count write beats the increment, so software reads back what it wrote
  wire [7:0] count_d = wr_count ? req.wdata :
                       pre_tick ? (match ? 8'h00 : 8'(count_q + 8'h01)) : count_q;
  // A set in the same cycle as a clear wins, so no period is lost
  wire flag_d = post_fire || (flag_q && !(wr_status && req.wdata[0]));
  // The mask takes effect at its write edge, so irq never lags it
  wire mask_d = wr_mask ? req.wdata[0] : mask_q;

  // Instruction clock divider, free running so writes never shift its phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_q <= 2'h0;
    end else begin
      instr_q <= instr_tick ? 2'h0 : 2'(instr_q + 2'h1);
    end
  end

  // Control, period and count registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_q <= EPTMR_CONTROL_RST;
      period_q <= EPTMR_PERIOD_RST;
      count_q <= EPTMR_COUNT_RST;
    end else begin
      // Top control bit is dropped on write, so it always reads back zero
      if (wr_control) begin
        control_q <= req.wdata & EPTMR_CONTROL_MASK;
      end
      if (wr_period) begin
        period_q <= req.wdata;
      end
      count_q <= count_d;
    end
  end

  // Scalers, flag and mask
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 4'h0;
      post_q <= 4'h0;
      flag_q <= 1'b0;
      mask_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      post_q <= post_d;
      flag_q <= flag_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // Read path and outputs
  // ----------------------------------------
  // Unmapped offsets read as zero
  wire [7:0] rd_mux = (req.addr == EPTMR_OFF_CONTROL) ? control_q :
                      (req.addr == EPTMR_OFF_PERIOD) ? period_q :
                      (req.addr == EPTMR_OFF_COUNT) ? count_q :
                      (req.addr == EPTMR_OFF_STATUS) ? {7'h00, flag_q} :
                      (req.addr == EPTMR_OFF_MASK) ? {7'h00, mask_q} : 8'h00;

  // Registered outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      count_out <= 8'h00;
    end else begin
      reg_rdata <= req.rd ? rd_mux : 8'h00;
      // Built from the next flag and mask so irq matches both exactly
      irq <= flag_d && mask_d;
      count_out <= count_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Datapath and register properties; reset disables them all
  ctl_top_zero_a: assert property (control_q[7] == 1'b0)
    else $error("control top bit set");
  stop_holds_a: assert property (!ctl.timer_run && !wr_count |=> $stable(count_q))
    else $error("count moved while stopped");
  wrap_zero_a: assert property (pre_tick && match && !wr_count |=> count_q == 8'h00)
    else $error("count did not wrap on match");
  step_one_a: assert property (pre_tick && !match && !wr_count
                               |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not step by one");
  flag_set_a: assert property (post_fire |=> flag_q)
    else $error("flag not set on postscaler output");
  flag_sticky_a: assert property (flag_q && !wr_status |=> flag_q)
    else $error("flag dropped without clear");
  scaler_clear_a: assert property (scaler_clr |=> pre_q == 4'h0 && post_q == 4'h0)
    else $error("scalers not cleared by write");
  post_range_a: assert property (post_q <= ctl.post_divide_select || $past(wr_control))
    else $error("postscaler beyond selected ratio");
  pre_range_a: assert property (instr_tick && ctl.timer_run &&
                                ctl.pre_divide_select == 2'h0 && !scaler_clr |-> pre_tick)
    else $error("divide by one missed a tick");
  irq_level_a: assert property (irq == (flag_q && mask_q))
    else $error("irq differs from unmasked flag");

  // Write side effects, scaler and divider wraps and holds, and register loads
  flag_clear_a: assert property (wr_status && req.wdata[0] && !post_fire |=> !flag_q)
    else $error("flag not cleared by write of one");
  post_wrap_a: assert property (post_fire |=> post_q == 4'h0)
    else $error("postscaler did not restart after firing");
  post_hold_a: assert property (!(pre_tick && match) && !scaler_clr |=> $stable(post_q))
    else $error("postscaler moved without a match");
  pre_hold_a: assert property (!ctl.timer_run && !scaler_clr |=> $stable(pre_q))
    else $error("prescaler moved while stopped");
  instr_wrap_a: assert property (instr_tick |=> instr_q == 2'h0)
    else $error("instruction divider did not wrap");
  keep_count_a: assert property (wr_control && !pre_tick |=> $stable(count_q))
    else $error("control write changed the count");
  count_load_a: assert property (wr_count |=> count_q == $past(req.wdata))
    else $error("count write not loaded");
  period_load_a: assert property (wr_period |=> period_q == $past(req.wdata))
    else $error("period write not loaded");
  period_hold_a: assert property (!wr_period |=> $stable(period_q))
    else $error("period changed without a write");
  ctl_read_a: assert property (req.rd && req.addr == EPTMR_OFF_CONTROL
                               |=> !reg_rdata[7])
    else $error("control top bit read as one");

  // Scenario covers
  match_cov_c: cover property (pre_tick && match);
  fire_cov_c: cover property (post_fire && ctl.post_divide_select == 4'hf);
  clear_cov_c: cover property (flag_q && wr_status && req.wdata[0]);
  stop_cov_c: cover property (wr_control && ctl.timer_run && !req.wdata[EPTMR_RUN_BIT]);
  slow_cov_c: cover property (pre_tick && ctl.pre_divide_select[1]);
endmodule

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the eight-bit period timer
// Assumes: Design assertions and covers stand inside the design file
// Notes: Read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module tb_top;
  import eptmr_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] reg_rdata, count_out;
  logic irq;
  logic [7:0] exp_q[$];
  logic [3:0] n;
  logic [7:0] per;
  int mismatches = 0;
  int tests_run = 0;
  int t, e, pre;
  eptmr_timer i_eptmr_timer (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .count_out(count_out));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  // Clock toggles every half period
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One-cycle write, then one idle edge so strobes never collide
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  // One-cycle read; expected value is noted for the monitor
  task automatic rd(input logic [2:0] a, input logic [7:0] d);
    exp_q.push_back(d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Monitor compares read data in the cycle after each read strobe
  always @(posedge core_clk) begin
    rd_q <= reg_rd;
    if (rd_q && exp_q.size() > 0)
      chk(reg_rdata === exp_q.pop_front(), "read data");
  end
  // Watchdog cuts a hang short
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h16a43497));
    do_reset();
    rd(EPTMR_OFF_CONTROL, 8'h00);
    rd(EPTMR_OFF_PERIOD, 8'hff);
    rd(EPTMR_OFF_COUNT, 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    wr(EPTMR_OFF_CONTROL, 8'hfb);
    rd(EPTMR_OFF_CONTROL, 8'h7b);
    wr(EPTMR_OFF_COUNT, 8'h5a);
    wr(EPTMR_OFF_CONTROL, 8'h00);
    rd(EPTMR_OFF_COUNT, 8'h5a);
    #1 chk(count_out === 8'h5a, "count lost on control write");
    repeat (40) @(posedge core_clk);
    #1 chk(count_out === 8'h5a, "stopped count moved");
    for (int p = 0; p < 4; p++) begin
      per = 8'($urandom_range(7, 1));
      n = 4'($urandom_range(15, 0));
      pre = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      e = EPTMR_INSTR_DIV * pre * (int'(per) + 1) * (int'(n) + 1);
      wr(EPTMR_OFF_PERIOD, per);
      wr(EPTMR_OFF_MASK, 8'h01);
      wr(EPTMR_OFF_STATUS, 8'h01);
      wr(EPTMR_OFF_COUNT, 8'h00);
      wr(EPTMR_OFF_CONTROL, {1'b0, n, 1'b1, 2'(p)});
      t = 0;
      #1;
      while (irq !== 1'b1 && t < e + 20) begin
        #5;
        t++;
      end
      chk(t >= e - 4 * pre - 8 && t <= e + 12, "irq timing");
      @(posedge core_clk);
      wr(EPTMR_OFF_CONTROL, 8'h00);
      repeat (20) @(posedge core_clk);
      #1 chk(irq === 1'b1, "flag not sticky");
      rd(EPTMR_OFF_STATUS, 8'h01);
      wr(EPTMR_OFF_MASK, 8'h00);
      #1 chk(irq === 1'b0, "mask ignored");
      wr(EPTMR_OFF_STATUS, 8'h01);
      wr(EPTMR_OFF_MASK, 8'h01);
      #1 chk(irq === 1'b0, "flag not cleared");
    end
    per = 8'($urandom_range(254, 1));
    wr(EPTMR_OFF_COUNT, per);
    rd(EPTMR_OFF_COUNT, per);
    do_reset();
    rd(EPTMR_OFF_PERIOD, 8'hff);
    rd(EPTMR_OFF_COUNT, 8'h00);
    rd(EPTMR_OFF_STATUS, 8'h00);
    repeat (2) @(posedge core_clk);
    end_sim();
  end
endmodule
